// [shared/asp_pkg.sv]
// constants and types for the async serial port block
// assumes a 16-bit register port with 8-bit registers in the low byte
package asp_pkg;
	// register window: ten registers, one per address from the base
	localparam logic [11:0] ASP_BASE_HI = 12'h705;
	localparam logic [3:0] ASP_NUM_REGS = 4'hA;
	localparam logic [3:0] REG_CHAR = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h1;
	localparam logic [3:0] REG_BAUD_HI = 4'h2;
	localparam logic [3:0] REG_BAUD_LO = 4'h3;
	localparam logic [3:0] REG_INT_MASK = 4'h4;
	localparam logic [3:0] REG_INT_STAT = 4'h5;
	localparam logic [3:0] REG_RX_BUF = 4'h6;
	localparam logic [3:0] REG_TX_BUF = 4'h7;
	localparam logic [3:0] REG_PIN = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'h9;
	// character format fields (length field is bits 2:0, holds length-1)
	localparam int CH_PAR_EN = 3;
	localparam int CH_PAR_EVEN = 4;
	localparam int CH_WAKE_EN = 5;
	localparam int CH_WAKE_ADDR = 6;
	localparam int CH_STOP2 = 7;
	// control fields
	localparam int CT_RX_EN = 0;
	localparam int CT_TX_EN = 1;
	localparam int CT_SLEEP = 2;
	localparam int CT_TX_WAKE = 3;
	localparam int CT_SERIAL = 4;
	localparam int CT_RX_WAKE = 7;
	// interrupt status and mask fields
	localparam int IS_TX_RDY = 0;
	localparam int IS_RX_RDY = 1;
	localparam int IS_BREAK = 2;
	localparam int IS_ERROR = 3;
	// status fields
	localparam int ST_TX_RDY = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_RX_RDY = 2;
	localparam int ST_RX_ERR = 3;
	localparam int ST_BRK = 4;
	localparam int ST_PE = 5;
	localparam int ST_OE = 6;
	localparam int ST_FE = 7;
	// pin fields
	localparam int PN_TX_OUT = 0;
	localparam int PN_TX_DRV = 1;
	localparam int PN_RX_OUT = 2;
	localparam int PN_RX_DRV = 3;
	localparam int PN_TX_IN = 4;
	localparam int PN_RX_IN = 5;
	// reset values
	localparam logic [7:0] CHAR_RST = 8'h07;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] PIN_RST = 8'h00;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	// bit timing: eight divider ticks per bit, sample on the fourth
	localparam logic [2:0] OVS_LAST = 3'h7;
	localparam logic [2:0] SAMPLE_TICK = 3'h3;
	localparam logic [3:0] IDLE_WAKE_BITS = 4'hA;
	localparam logic [3:0] GAP_BITS = 4'hB;
	localparam int FRAME_MAX = 13;
	typedef enum logic [1:0] {TX_IDLE, TX_GAP, TX_SEND} asp_tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_type;
endpackage

// [logic/asp_async_serial_port.sv]
// async serial port: framing, divider, double buffers, flags, gpio mux
// assumes the register master keeps strobes one cycle and never both
// Function
// R1 - a frame is one low start bit then one to eight data bits.
// R2 - an optional parity bit, even or odd, follows the data.
// R3 - one or two stop bits end the frame and the receiver checks them.
// R4 - a 16-bit divisor derives the bit rate from the core clock.
// R5 - the divider reaches the top rate of the clock over eight.
// R6 - each character is checked for parity, overrun, framing and break.
// R7 - idle-line and address-bit wake-up schemes are offered.
// R8 - transmit and receive each hold a buffer before the shifter.
// R9 - transmitter and receiver have their own enables.
// R10 - transmit ready and transmit empty flags are shown.
// R11 - receive ready, break and a summary error flag are shown.
// R12 - tx and rx interrupts have own enables, break has its own.
// R13 - ten registers sit from base 7050h.
// R14 - registers are eight bits, upper byte reads zero, writes ignored.
// R15 - both pins act as general-purpose pins when serial is off.
// R16 - the line idles high, data goes lsb first, sampled mid-bit.
`timescale 1ns/1ps
module asp_async_serial_port
	import asp_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// register port
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [15:0] o_rd_data,
	// interrupt
	output logic o_irq,
	// transmit pin
	input wire logic i_serial_tx_pin,
	output logic o_serial_tx_pin,
	output logic o_serial_tx_pin_oe_n,
	// receive pin
	input wire logic i_serial_rx_pin,
	output logic o_serial_rx_pin,
	output logic o_serial_rx_pin_oe_n
);
	logic [7:0] char_cfg, ctrl, int_mask, int_stat, pin_cfg, tx_buf, rx_buf;
	logic [15:0] baud, baud_cnt;
	logic tx_full, rx_rdy, pe, fe, oe, brk, rx_wake;
	logic [1:0] sync1, sync2, sync3, pin_lvl;
	logic [3:0] len, pos_addr, pos_par, pos_stop, frame_len;
	logic tick, rx_line, wake_on, addr_mode, tx_load;
	logic wr_hit, rd_hit;
	logic [3:0] off;

	// register decode
	assign off = i_addr[3:0];
	assign wr_hit = i_wr_en && i_addr[15:4] == ASP_BASE_HI
		&& off < ASP_NUM_REGS; // see R13
	assign rd_hit = i_rd_en && i_addr[15:4] == ASP_BASE_HI
		&& off < ASP_NUM_REGS;

	// frame layout shared by both directions
	assign len = {1'b0, char_cfg[2:0]} + 4'h1;
	assign wake_on = char_cfg[CH_WAKE_EN];
	assign addr_mode = wake_on && char_cfg[CH_WAKE_ADDR];
	assign pos_addr = len + 4'h1;
	assign pos_par = pos_addr + {3'h0, addr_mode};
	assign pos_stop = pos_par + {3'h0, char_cfg[CH_PAR_EN]}; // see R2
	assign frame_len = pos_stop + {3'h0, char_cfg[CH_STOP2]} + 4'h1; // see R3

	// pin synchroniser: a level is taken once stages two and three agree
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			sync3 <= 2'h3;
			pin_lvl <= 2'h3;
		end
		else
		begin
			sync1 <= {i_serial_rx_pin, i_serial_tx_pin};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= (sync2 ~^ sync3) & sync3 | (sync2 ^ sync3) & pin_lvl;
		end
	end
	assign rx_line = pin_lvl[1];

	// bit-rate divider: one tick every baud+1 clocks, eight per bit
	logic [15:0] next_baud_cnt;
	always_comb
	begin
		next_baud_cnt = baud_cnt + 16'h0001;
		if (tick || !(ctrl[CT_TX_EN] || ctrl[CT_RX_EN]))
			next_baud_cnt = 16'h0000;
	end
	// greater-or-equal so a divisor lowered mid-count cannot stall a wrap
	assign tick = baud_cnt >= baud; // see R4 R5
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			baud_cnt <= 16'h0000;
		else
			baud_cnt <= next_baud_cnt;
	end

	// transmitter: loads from the buffer, optional idle gap, then shifts
	asp_tx_state_type tx_state, next_tx_state;
	logic [FRAME_MAX-1:0] tx_frame, next_tx_frame, tx_fr;
	logic [3:0] tx_bits, next_tx_bits, tx_len, next_tx_len;
	logic [2:0] tx_ovs, next_tx_ovs;
	logic tx_line, next_tx_line;
	logic [7:0] tx_data;
	always_comb
	begin
		tx_fr = '1;
		tx_fr[0] = 1'b0; // see R1
		for (int i = 0; i < 8; i++)
			tx_data[i] = (4'(i) < len) ? tx_buf[i] : 1'b0;
		for (int i = 0; i < 8; i++)
			if (4'(i) < len)
				tx_fr[1 + i] = tx_buf[i]; // see R16
		if (addr_mode)
			tx_fr[pos_addr] = ctrl[CT_TX_WAKE]; // see R7
		if (char_cfg[CH_PAR_EN])
			tx_fr[pos_par] = ^tx_data ^ !char_cfg[CH_PAR_EVEN]; // see R2
	end
	always_comb
	begin
		next_tx_state = tx_state;
		next_tx_frame = tx_frame;
		next_tx_bits = tx_bits;
		next_tx_len = tx_len;
		next_tx_ovs = tx_ovs;
		tx_load = 1'b0;
		case (tx_state)
			TX_IDLE:
			begin
				// shifter frees up the buffer as soon as it loads
				if (ctrl[CT_TX_EN] && tx_full) // see R8 R9
				begin
					tx_load = 1'b1;
					next_tx_frame = tx_fr;
					next_tx_len = frame_len;
					next_tx_ovs = 3'h0;
					if (wake_on && !addr_mode && ctrl[CT_TX_WAKE])
					begin
						next_tx_state = TX_GAP; // see R7
						next_tx_bits = GAP_BITS;
					end
					else
					begin
						next_tx_state = TX_SEND;
						next_tx_bits = frame_len;
					end
				end
			end
			TX_GAP, TX_SEND:
			begin
				if (tick)
				begin
					next_tx_ovs = tx_ovs + 3'h1;
					if (tx_ovs == OVS_LAST)
					begin
						next_tx_bits = tx_bits - 4'h1;
						if (tx_state == TX_SEND)
							next_tx_frame = {1'b1, tx_frame[FRAME_MAX-1:1]};
						if (tx_bits == 4'h1 && tx_state == TX_GAP)
						begin
							next_tx_state = TX_SEND;
							next_tx_bits = tx_len;
						end
						else if (tx_bits == 4'h1)
							next_tx_state = TX_IDLE;
					end
				end
			end
			default:
				next_tx_state = TX_IDLE;
		endcase
		next_tx_line = (next_tx_state == TX_SEND) ? next_tx_frame[0] : 1'b1;
	end
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			tx_state <= TX_IDLE;
			tx_frame <= '1;
			tx_bits <= 4'h0;
			tx_len <= 4'h0;
			tx_ovs <= 3'h0;
			tx_line <= 1'b1;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_frame <= next_tx_frame;
			tx_bits <= next_tx_bits;
			tx_len <= next_tx_len;
			tx_ovs <= next_tx_ovs;
			tx_line <= next_tx_line;
		end
	end

	// receiver: start qualify, mid-bit sampling, idle-line counting
	asp_rx_state_type rx_state, next_rx_state;
	logic [FRAME_MAX-1:0] rx_bits, next_rx_bits;
	logic [3:0] rx_idx, next_rx_idx, idle_cnt, next_idle_cnt;
	logic [2:0] rx_ovs, next_rx_ovs;
	logic rx_done, next_rx_done, idle_seen, next_idle_seen;
	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_bits = rx_bits;
		next_rx_idx = rx_idx;
		next_idle_cnt = idle_cnt;
		next_rx_ovs = rx_ovs;
		next_idle_seen = idle_seen;
		next_rx_done = 1'b0;
		if (tick)
			next_rx_ovs = rx_ovs + 3'h1;
		case (rx_state)
			RX_IDLE:
			begin
				if (tick && !rx_line)
				begin
					next_rx_state = RX_START;
					next_rx_ovs = 3'h0;
					next_rx_bits = '0;
					next_idle_seen = idle_cnt >= IDLE_WAKE_BITS; // see R7
				end
				else if (tick && rx_ovs == OVS_LAST
					&& idle_cnt < IDLE_WAKE_BITS)
					next_idle_cnt = idle_cnt + 4'h1;
			end
			RX_START:
			begin
				// a start that is high again at mid-bit was a glitch
				if (tick && rx_ovs == SAMPLE_TICK)
				begin
					next_rx_state = rx_line ? RX_IDLE : RX_BITS;
					next_rx_idx = 4'h1;
				end
			end
			RX_BITS:
			begin
				if (tick && rx_ovs == SAMPLE_TICK)
				begin
					next_rx_bits[rx_idx] = rx_line; // see R16
					next_rx_idx = rx_idx + 4'h1;
					if (rx_idx == frame_len - 4'h1) // see R3
					begin
						next_rx_state = RX_IDLE;
						next_rx_done = 1'b1;
						next_idle_cnt = 4'h0;
						next_rx_ovs = 3'h0;
					end
				end
			end
			default:
				next_rx_state = RX_IDLE;
		endcase
		if (!rx_line && rx_state == RX_IDLE)
			next_idle_cnt = 4'h0;
		if (!ctrl[CT_RX_EN] || !ctrl[CT_SERIAL]) // see R9
		begin
			next_rx_state = RX_IDLE;
			next_rx_done = 1'b0;
		end
	end
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			rx_state <= RX_IDLE;
			rx_bits <= '0;
			rx_idx <= 4'h0;
			idle_cnt <= 4'h0;
			rx_ovs <= 3'h0;
			rx_done <= 1'b0;
			idle_seen <= 1'b0;
		end
		else
		begin
			rx_state <= next_rx_state;
			rx_bits <= next_rx_bits;
			rx_idx <= next_rx_idx;
			idle_cnt <= next_idle_cnt;
			rx_ovs <= next_rx_ovs;
			rx_done <= next_rx_done;
			idle_seen <= next_idle_seen;
		end
	end

	// received frame checks
	logic [7:0] rx_data;
	logic stop_ok, par_bad, is_brk, accept, rd_rxbuf;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			rx_data[i] = (4'(i) < len) ? rx_bits[1 + i] : 1'b0;
		stop_ok = rx_bits[pos_stop]
			&& (!char_cfg[CH_STOP2] || rx_bits[pos_stop + 4'h1]);
		par_bad = char_cfg[CH_PAR_EN] && (rx_bits[pos_par]
			!= (^rx_data ^ !char_cfg[CH_PAR_EVEN])); // see R6
		is_brk = rx_bits == '0; // line low through the stop bits
		// while asleep with wake-up on, only a waking character is passed up
		accept = rx_done && (!ctrl[CT_SLEEP] || !wake_on
			|| (addr_mode ? rx_bits[pos_addr] : idle_seen)); // see R7
		rd_rxbuf = rd_hit && off == REG_RX_BUF;
	end

	// registers, flags and interrupt
	logic [7:0] next_char_cfg, next_ctrl, next_int_mask, next_int_stat;
	logic [7:0] next_pin_cfg, next_tx_buf, next_rx_buf, rd_mux, ev;
	logic [15:0] next_baud, next_rd_data;
	logic next_tx_full, next_rx_rdy, next_pe, next_fe, next_oe, next_brk;
	logic next_rx_wake, next_irq, tx_empty, rx_err;
	logic next_tx_pin, next_tx_oe_n, next_rx_pin, next_rx_oe_n;
	assign tx_empty = tx_state == TX_IDLE && !tx_full; // see R10
	assign rx_err = pe || oe || fe || brk; // see R11
	always_comb
	begin
		next_char_cfg = char_cfg;
		next_ctrl = ctrl;
		next_baud = baud;
		next_int_mask = int_mask;
		next_pin_cfg = pin_cfg;
		next_tx_buf = tx_buf;
		next_rx_buf = rx_buf;
		next_tx_full = tx_full && !tx_load;
		next_rx_rdy = rx_rdy && !rd_rxbuf;
		next_pe = pe;
		next_fe = fe;
		next_oe = oe;
		next_brk = brk;
		next_rx_wake = rx_wake;
		if (tx_load && addr_mode)
			next_ctrl[CT_TX_WAKE] = 1'b0;
		if (tx_load && wake_on && !addr_mode)
			next_ctrl[CT_TX_WAKE] = 1'b0;
		// only the low byte is written; the upper byte is dropped
		if (wr_hit) // see R14
		begin
			case (off)
				REG_CHAR: next_char_cfg = i_wr_data[7:0];
				REG_CTRL: next_ctrl = {1'b0, i_wr_data[6:0]};
				REG_BAUD_HI: next_baud[15:8] = i_wr_data[7:0];
				REG_BAUD_LO: next_baud[7:0] = i_wr_data[7:0];
				REG_INT_MASK: next_int_mask = i_wr_data[7:0];
				REG_PIN: next_pin_cfg = i_wr_data[7:0];
				REG_TX_BUF:
				begin
					next_tx_buf = i_wr_data[7:0];
					next_tx_full = 1'b1; // see R8
				end
				REG_STATUS:
				begin
					next_pe = pe && !i_wr_data[ST_PE];
					next_fe = fe && !i_wr_data[ST_FE];
					next_oe = oe && !i_wr_data[ST_OE];
					next_brk = brk && !i_wr_data[ST_BRK];
				end
				default: next_rx_buf = rx_buf;
			endcase
		end
		next_ctrl[CT_RX_WAKE] = rx_wake;
		// hardware events come last so a set beats a clear
		if (accept)
		begin
			next_rx_buf = rx_data;
			next_oe = oe || (rx_rdy && !rd_rxbuf); // see R6
			next_rx_rdy = 1'b1; // see R11
			next_pe = par_bad;
			next_fe = !stop_ok;
			next_rx_wake = addr_mode ? rx_bits[pos_addr] : idle_seen;
		end
		if (rx_done && !stop_ok && is_brk)
			next_brk = 1'b1; // see R6
		ev = 8'h00;
		ev[IS_TX_RDY] = tx_load;
		ev[IS_RX_RDY] = accept;
		ev[IS_BREAK] = rx_done && !stop_ok && is_brk;
		ev[IS_ERROR] = accept && (par_bad || !stop_ok || rx_rdy);
		next_int_stat = int_stat;
		if (wr_hit && off == REG_INT_STAT)
			next_int_stat = int_stat & ~i_wr_data[7:0];
		next_int_stat = next_int_stat | ev;
		// break has its own mask bit apart from the rx one
		next_irq = |(int_stat & int_mask); // see R12
		case (off)
			REG_CHAR: rd_mux = char_cfg;
			REG_CTRL: rd_mux = ctrl;
			REG_BAUD_HI: rd_mux = baud[15:8];
			REG_BAUD_LO: rd_mux = baud[7:0];
			REG_INT_MASK: rd_mux = int_mask;
			REG_INT_STAT: rd_mux = int_stat;
			REG_RX_BUF: rd_mux = rx_buf;
			REG_TX_BUF: rd_mux = tx_buf;
			REG_PIN: rd_mux = {2'h0, pin_lvl, pin_cfg[3:0]};
			REG_STATUS: rd_mux = {fe, oe, pe, brk, rx_err, rx_rdy,
				tx_empty, !tx_full};
			default: rd_mux = 8'h00;
		endcase
		next_rd_data = rd_hit ? {8'h00, rd_mux} : 16'h0000; // see R14
		// pins fall back to plain port use when serial is off
		next_tx_pin = ctrl[CT_SERIAL] ? tx_line : pin_cfg[PN_TX_OUT];
		next_tx_oe_n = ctrl[CT_SERIAL] ? 1'b0 : !pin_cfg[PN_TX_DRV];
		next_rx_pin = ctrl[CT_SERIAL] ? 1'b0 : pin_cfg[PN_RX_OUT];
		next_rx_oe_n = ctrl[CT_SERIAL] || !pin_cfg[PN_RX_DRV]; // see R15
	end
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			char_cfg <= CHAR_RST;
			ctrl <= CTRL_RST;
			baud <= BAUD_RST;
			int_mask <= MASK_RST;
			int_stat <= 8'h00;
			pin_cfg <= PIN_RST;
			tx_buf <= 8'h00;
			rx_buf <= 8'h00;
			{tx_full, rx_rdy, pe, fe, oe, brk, rx_wake, o_irq} <= 8'h00;
			o_rd_data <= 16'h0000;
			{o_serial_tx_pin, o_serial_tx_pin_oe_n} <= 2'h1;
			{o_serial_rx_pin, o_serial_rx_pin_oe_n} <= 2'h1;
		end
		else
		begin
			char_cfg <= next_char_cfg;
			ctrl <= next_ctrl;
			baud <= next_baud;
			int_mask <= next_int_mask;
			int_stat <= next_int_stat;
			pin_cfg <= next_pin_cfg;
			tx_buf <= next_tx_buf;
			rx_buf <= next_rx_buf;
			tx_full <= next_tx_full;
			rx_rdy <= next_rx_rdy;
			pe <= next_pe;
			fe <= next_fe;
			oe <= next_oe;
			brk <= next_brk;
			rx_wake <= next_rx_wake;
			o_irq <= next_irq;
			o_rd_data <= next_rd_data;
			o_serial_tx_pin <= next_tx_pin;
			o_serial_tx_pin_oe_n <= next_tx_oe_n;
			o_serial_rx_pin <= next_rx_pin;
			o_serial_rx_pin_oe_n <= next_rx_oe_n;
		end
	end

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_load;
		tx_state == TX_IDLE && tx_load ##1 tx_state == TX_SEND;
	endsequence
	start_bit_low_a: assert property (s_load |-> !tx_line) // see R1
		else $error("start bit not low");
	idle_line_high_a: assert property (tx_state == TX_IDLE |-> tx_line)
		else $error("idle line not high"); // see R16
	tx_hold_off_a: assert property ( // see R9
		tx_state == TX_IDLE && !ctrl[CT_TX_EN] |=> tx_state == TX_IDLE)
		else $error("tx started while disabled");
	tx_buf_fill_a: assert property ( // see R10
		wr_hit && off == REG_TX_BUF |=> tx_full && !tx_empty)
		else $error("tx buffer write not seen");
	rx_ready_set_a: assert property ( // see R11
		accept |=> rx_rdy ##0 rx_buf == $past(rx_data))
		else $error("received char not buffered");
	overrun_flag_a: assert property ( // see R6
		accept && rx_rdy && !rd_rxbuf |=> oe)
		else $error("overrun missed");
	irq_follow_a: assert property ( // see R12
		|(int_stat & int_mask) |=> o_irq)
		else $error("irq not raised");
	upper_byte_zero_a: assert property (o_rd_data[15:8] == 8'h00)
		else $error("upper byte not zero"); // see R14
	tick_spacing_a: assert property ( // see R4
		tick && baud != 16'h0000 && next_baud == baud |=> !tick)
		else $error("divider ticks too close");
	gpio_release_a: assert property ( // see R15
		ctrl[CT_SERIAL] |=> !o_serial_rx_pin_oe_n == 1'b0)
		else $error("rx pin driven in serial mode");
endmodule

// [tb/asp_peer_uart.sv]
// peer serial device: drives the receive pin, samples the transmit pin
// assumes bit_clks holds the bit time in core clocks; lines pulled up idle
`timescale 1ns/1ps
module asp_peer_uart
(
	// clock
	input wire logic i_core_clk,
	// serial lines
	input wire logic i_line,
	output logic o_line
);
	int bit_clks = 16;

	// the line rests high between frames
	initial o_line = 1'b1;

	// bit 0 of the frame goes first; the caller builds every field
	task automatic send(input logic [12:0] frame, input int n);
		for (int i = 0; i < n; i++)
		begin
			o_line <= frame[i];
			repeat (bit_clks) @(posedge i_core_clk);
		end
		o_line <= 1'b1;
		// one idle edge so a following frame never retimes the line twice
		@(posedge i_core_clk);
	endtask

	// wait for a start edge, then sample each bit near its middle
	task automatic recv(input int n, output logic [12:0] frame,
		output bit ok);
		int t;
		// unsent positions read as idle high, like the expected frame
		frame = '1;
		// falling edges keep the samples clear of the launching edge
		for (t = 0; t < 4000 && i_line !== 1'b0; t++)
			@(negedge i_core_clk);
		ok = (i_line === 1'b0);
		if (ok)
		begin
			repeat (bit_clks / 2) @(negedge i_core_clk);
			for (int i = 0; i < n; i++)
			begin
				frame[i] = i_line;
				// stop at the last middle so a following start is not missed
				if (i < n - 1)
					repeat (bit_clks) @(negedge i_core_clk);
			end
		end
	endtask
endmodule

// [tb/testbench.sv]
// top bench for the async serial port: registers, pins, frames, irq
// assumes the peer model on both pins and a 200 MHz core clock
`timescale 1ns/1ps
module testbench
	import asp_pkg::*;
;
	logic i_core_clk;
	logic i_resetn;
	logic [15:0] i_addr;
	logic [15:0] i_wr_data;
	logic i_wr_en;
	logic i_rd_en;
	logic [15:0] o_rd_data;
	logic o_irq;
	logic o_tx;
	logic o_tx_oe_n;
	logic o_rx;
	logic o_rx_oe_n;
	logic tx_line;
	logic rx_line;
	logic peer_line;
	int err_total = 0;
	int checks = 0;
	logic [7:0] rst_v [10] = '{CHAR_RST, CTRL_RST, 8'h00, 8'h00, MASK_RST,
		8'h00, 8'h00, 8'h00, 8'h30, 8'h03};
	logic [7:0] tx_ch [4] = '{8'h07, 8'h80, 8'h0E, 8'h9C};
	logic [7:0] tx_d [4] = '{8'hA5, 8'h01, 8'h3C, 8'h13};
	logic [7:0] rx_msk [5] = '{8'h02, 8'h08, 8'h08, 8'h04, 8'h08};
	logic [7:0] rx_st [5] = '{8'h00, 8'h28, 8'h88, 8'h98, 8'h48};
	logic [7:0] rx_is [5] = '{8'h02, 8'h0A, 8'h0A, 8'h04, 8'h0A};
	logic [7:0] rx_ism [5] = '{8'h0E, 8'h0E, 8'h0E, 8'h04, 8'h0E};

	// when the block does not drive them, the tx pin is pulled up and the rx pin follows the peer
	assign tx_line = o_tx_oe_n ? 1'b1 : o_tx;
	assign rx_line = o_rx_oe_n ? peer_line : o_rx;

	asp_async_serial_port u_asp_async_serial_port (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_addr(i_addr),
		.i_wr_data(i_wr_data),
		.i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en),
		.o_rd_data(o_rd_data),
		.o_irq(o_irq),
		.i_serial_tx_pin(tx_line),
		.o_serial_tx_pin(o_tx),
		.o_serial_tx_pin_oe_n(o_tx_oe_n),
		.i_serial_rx_pin(rx_line),
		.o_serial_rx_pin(o_rx),
		.o_serial_rx_pin_oe_n(o_rx_oe_n)
	);

	asp_peer_uart u_asp_peer_uart (
		.i_core_clk(i_core_clk),
		.i_line(tx_line),
		.o_line(peer_line)
	);

	// 200 MHz core clock
	initial
	begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [3:0] off, input logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= {ASP_BASE_HI, off};
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_core_clk);
		i_wr_en <= 1'b0;
	endtask

	// read strobe; data stands only in the following cycle
	task automatic rd(input logic [3:0] off, output logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= {ASP_BASE_HI, off};
		i_rd_en <= 1'b1;
		@(posedge i_core_clk);
		i_rd_en <= 1'b0;
		#1 d = o_rd_data;
	endtask

	// expected frame: start, data lsb first, address bit, parity, stops
	function automatic int mk(input logic [7:0] d, input logic [7:0] ch,
		input int ab, output logic [12:0] f);
		int n;
		logic p;
		f = '1;
		f[0] = 1'b0;
		n = 1;
		p = 1'b0;
		for (int i = 0; i <= int'(ch[2:0]); i++)
		begin
			f[n] = d[i];
			p ^= d[i];
			n++;
		end
		if (ab >= 0)
		begin
			f[n] = ab[0];
			n++;
		end
		if (ch[CH_PAR_EN])
		begin
			f[n] = ch[CH_PAR_EVEN] ? p : ~p;
			n++;
		end
		return n + 1 + int'(ch[CH_STOP2]);
	endfunction

	// bounded wait for the interrupt line
	task automatic wait_irq();
		for (int t = 0; t < 2000 && o_irq !== 1'b1; t++)
			@(posedge i_core_clk);
		check("irq raised", 16'h0001, {15'h0, o_irq});
		if (o_irq !== 1'b1)
			end_of_test();
	endtask

	// stage one character and compare what the peer hears
	task automatic tx_chk(input logic [7:0] ch, input logic [7:0] d);
		logic [12:0] f;
		logic [12:0] g;
		bit ok;
		int n;
		n = mk(d, ch, -1, f);
		wr(REG_CHAR, {8'h00, ch});
		fork
			u_asp_peer_uart.recv(n, g, ok);
			wr(REG_TX_BUF, {8'h00, d});
		join
		check("tx frame", {3'h0, f}, {3'h0, g});
		if (!ok)
			end_of_test();
	endtask

	// one received character (two back to back for k 4), good or broken in the way k selects
	task automatic rx_case(input int k);
		logic [12:0] f;
		logic [15:0] v;
		int n;
		n = mk(8'h5A, 8'h1F, -1, f);
		if (k == 1)
			f[9] = ~f[9];
		if (k == 2)
			f[10] = 1'b0;
		if (k == 3)
			f = '0;
		wr(REG_INT_MASK, {8'h00, rx_msk[k]});
		if (k == 4)
			u_asp_peer_uart.send(f, n);
		u_asp_peer_uart.send(f, n);
		wait_irq();
		rd(REG_STATUS, v);
		check("rx errors", {8'h00, rx_st[k]}, v & 16'h00F8);
		rd(REG_INT_STAT, v);
		check("rx events", {8'h00, rx_is[k]}, v & {8'h00, rx_ism[k]});
		rd(REG_RX_BUF, v);
		if (k != 3)
			check("rx data", 16'h005A, v);
		wr(REG_STATUS, 16'h00F0);
		wr(REG_INT_STAT, 16'h000F);
		@(posedge i_core_clk);
		#1 check("irq cleared", 16'h0000, {15'h0, o_irq});
	endtask

	// main sequence
	initial
	begin
		logic [15:0] v;
		logic [12:0] f;
		logic [12:0] g1;
		logic [12:0] g2;
		bit ok;
		int n;
		int low;
		i_resetn = 1'b0;
		i_addr = '0;
		i_wr_data = '0;
		i_wr_en = 1'b0;
		i_rd_en = 1'b0;
		repeat (20) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		for (int k = 0; k < 10; k++)
			if (k != 6 && k != 7)
			begin
				rd(4'(k), v);
				check("reset value", {8'h00, rst_v[k]}, v);
			end
		rd(ASP_NUM_REGS, v);
		check("unmapped read", 16'h0000, v);
		wr(REG_BAUD_HI, 16'hFFAB);
		rd(REG_BAUD_HI, v);
		check("upper byte", 16'h00AB, v);
		$display("test registers done");
		// both pins as plain i/o while serial mode is off
		wr(REG_PIN, 16'h0003);
		repeat (5) @(posedge i_core_clk);
		check("tx gpio", 16'h0001, {14'h0, o_tx_oe_n, o_tx});
		rd(REG_PIN, v);
		check("pin high", 16'h0033, v);
		wr(REG_PIN, 16'h000A);
		repeat (5) @(posedge i_core_clk);
		check("rx gpio", 16'h0000, {14'h0, o_rx_oe_n, o_rx});
		rd(REG_PIN, v);
		check("pin low", 16'h000A, v);
		wr(REG_PIN, 16'h0000);
		$display("test gpio done");
		// divisor 1 gives 16 clocks a bit, the peer's default
		wr(REG_BAUD_HI, 16'h0000);
		wr(REG_BAUD_LO, 16'h0001);
		wr(REG_CTRL, 16'h0013);
		repeat (3) @(posedge i_core_clk);
		check("serial pins", 16'h0005, {13'h0, o_rx_oe_n, o_tx_oe_n,
			tx_line});
		for (int k = 0; k < 4; k++)
			tx_chk(tx_ch[k], tx_d[k]);
		// top rate: divisor 0, eight clocks a bit
		wr(REG_BAUD_LO, 16'h0000);
		u_asp_peer_uart.bit_clks = 8;
		tx_chk(8'h07, 8'h96);
		wr(REG_BAUD_LO, 16'h0001);
		u_asp_peer_uart.bit_clks = 16;
		n = mk(8'hC3, 8'h07, -1, f);
		fork
			begin
				wr(REG_TX_BUF, 16'h00C3);
				wr(REG_TX_BUF, 16'h003C);
				rd(REG_STATUS, v);
				check("tx both full", 16'h0000, v & 16'h0003);
			end
			begin
				u_asp_peer_uart.recv(n, g1, ok);
				u_asp_peer_uart.recv(n, g2, ok);
			end
		join
		check("first staged", {3'h0, f}, {3'h0, g1});
		n = mk(8'h3C, 8'h07, -1, f);
		check("second staged", {3'h0, f}, {3'h0, g2});
		v = '0;
		for (int t = 0; t < 50 && v[ST_TX_EMPTY] !== 1'b1; t++)
			rd(REG_STATUS, v);
		check("tx idle flags", 16'h0003, v & 16'h0003);
		if (v[ST_TX_EMPTY] !== 1'b1)
			end_of_test();
		rd(REG_INT_STAT, v);
		check("tx event", 16'h0001, v & 16'h0001);
		$display("test transmit done");
		wr(REG_CHAR, 16'h001F);
		for (int k = 0; k < 5; k++)
			rx_case(k);
		$display("test receive done");
		// address-bit wake-up while asleep
		wr(REG_CHAR, 16'h0067);
		wr(REG_CTRL, 16'h0017);
		n = mk(8'h11, 8'h67, 0, f);
		u_asp_peer_uart.send(f, n);
		rd(REG_STATUS, v);
		check("asleep", 16'h0000, v & 16'h0004);
		n = mk(8'h22, 8'h67, 1, f);
		u_asp_peer_uart.send(f, n);
		rd(REG_STATUS, v);
		check("woken", 16'h0004, v & 16'h0004);
		rd(REG_CTRL, v);
		check("wake bit", 16'h0080, v & 16'h0080);
		rd(REG_RX_BUF, v);
		check("address char", 16'h0022, v);
		// address bit sent from the tx wake bit, which then self-clears
		wr(REG_CTRL, 16'h001B);
		n = mk(8'h5C, 8'h67, 1, f);
		fork
			u_asp_peer_uart.recv(n, g1, ok);
			wr(REG_TX_BUF, 16'h005C);
		join
		check("address frame", {3'h0, f}, {3'h0, g1});
		rd(REG_CTRL, v);
		check("tx wake clear", 16'h0000, v & 16'h0008);
		$display("test wake done");
		// receiver alone: the staged character must not leave
		wr(REG_CTRL, 16'h0011);
		wr(REG_TX_BUF, 16'h0000);
		n = mk(8'h44, 8'h67, 0, f);
		low = 0;
		fork
			u_asp_peer_uart.send(f, n);
			// a wrongly enabled shifter would start inside this window
			repeat (64)
			begin
				@(posedge i_core_clk);
				low += (tx_line === 1'b0);
			end
		join
		check("tx disabled", 16'h0000, low[15:0]);
		rd(REG_RX_BUF, v);
		check("rx alone", 16'h0044, v);
		$display("test enables done");
		end_of_test();
	end
endmodule
